//--- hdl/eqsc_pkg.sv
// Constants shared by the equalizer serial control block
package eqsc_pkg;

  // ************************************************************
  // Register addresses (7-bit register select)
  // ************************************************************
  localparam logic [6:0] ADDR_IDENT = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_LENGTH = 7'h02;
  localparam logic [6:0] ADDR_GAIN = 7'h03;
  localparam logic [6:0] ADDR_OVERRIDE = 7'h04;
  localparam logic [6:0] ADDR_EQ_CTRL = 7'h05;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_LENGTH = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h20;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_EQ_CTRL = 8'h00;

  // ************************************************************
  // Field positions and masks
  // ************************************************************
  localparam int ADDR_RW_BIT = 7;
  localparam int CTRL_CABLE_BIT = 4;
  localparam int OVR_INV_SEL_BIT = 6;
  localparam int OVR_INV_VAL_BIT = 7;
  localparam logic [7:0] MASK_LENGTH = 8'h3F;
  localparam logic [7:0] MASK_EQ_CTRL = 8'h1F;
  localparam int ST_PRESENT = 0;
  localparam int ST_DLL = 1;
  localparam int ST_POLARITY = 2;
  localparam int ST_COLOR = 3;
  localparam int ST_OVERLOAD = 4;
  localparam int ST_SETTLED = 5;
  localparam logic [5:0] COAX_MAX_LEN = 6'h14;

  // ************************************************************
  // Serial frame and timing
  // ************************************************************
  localparam logic [4:0] ADDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int LOCK_LINES = 100;
  localparam int SYS_CLK_MHZ = 100;
  localparam int LOSS_TIME_US = 1000;
  localparam int LOSS_CYCLES = LOSS_TIME_US * SYS_CLK_MHZ;

  // ************************************************************
  // Modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    EQSC_CONT = 2'b00,
    EQSC_SLOSS = 2'b01,
    EQSC_LRST = 2'b10,
    EQSC_MAN = 2'b11
  } eqsc_mode_t;

  typedef enum logic [1:0] {
    EQSC_SEEK = 2'b00,
    EQSC_LOCK = 2'b01,
    EQSC_LOSS = 2'b11
  } eqsc_state_t;

endpackage

//--- hdl/eqsc_serial_ctrl.sv
// Serial register port and equalization mode control
`timescale 1ns/1ps

module eqsc_serial_ctrl #(
  parameter int LOSS_CYCLES = eqsc_pkg::LOSS_CYCLES,
  parameter logic [3:0] REVISION = 4'h0,
  // Arbitrary neutral value
  parameter logic [3:0] DEVICE_CODE = 4'hA
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic serial_clk,
  input wire logic serial_enable_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  // Analog status levels
  input wire logic signal_present,
  input wire logic dll_locked,
  input wire logic color_detected,
  input wire logic overloaded,
  input wire logic invert_pin_in,
  // Adaptation engine events
  input wire logic line_tick,
  input wire logic eq_step,
  // Equalizer controls
  output logic lock_out,
  output logic eq_freeze,
  output logic eq_restart,
  output logic manual_enable,
  output logic [5:0] manual_length,
  output logic cable_coax,
  output logic [5:0] manual_gain,
  output logic auto_pol_en,
  output logic pol_invert
);
  import eqsc_pkg::*;

  localparam int LW = $clog2(LOSS_CYCLES + 1);

  if (LOSS_CYCLES < 2) begin : g_check
    $error("LOSS_CYCLES must be at least 2");
  end

  // ************************************************************
  // Serial clock domain
  // ************************************************************
  // Enable low clears this domain asynchronously, so the frame ends
  // even though the serial clock stops outside frames.
  logic [4:0] bit_cnt;
  logic [7:0] addr_sr;
  logic [7:0] data_sr;
  logic [7:0] dout_sr;
  logic addr_done;
  logic frame_done;
  logic [7:0] read_word;

  wire is_read = addr_sr[ADDR_RW_BIT];
  wire take_addr = bit_cnt < ADDR_BITS;
  wire first_out = bit_cnt == ADDR_BITS && is_read;
  wire more_out = bit_cnt > ADDR_BITS && bit_cnt < FRAME_BITS && is_read;
  wire take_data = bit_cnt >= ADDR_BITS && bit_cnt < FRAME_BITS && !is_read;

  always_ff @(posedge serial_clk or negedge serial_enable_pin) begin
    if (!serial_enable_pin) begin
      bit_cnt <= 5'h00;
      addr_sr <= 8'h00;
      data_sr <= 8'h00;
      dout_sr <= 8'h00;
      addr_done <= 1'b0;
      frame_done <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else begin
      if (bit_cnt < FRAME_BITS) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (take_addr) begin
        addr_sr <= {addr_sr[6:0], serial_data_pin_in};
      end
      if (take_data) begin
        data_sr <= {data_sr[6:0], serial_data_pin_in};
      end
      // read_word settled one serial period earlier
      if (first_out) begin
        dout_sr <= read_word;
        serial_data_pin_out <= read_word[7];
        serial_data_pin_oe <= 1'b1;
      end else if (more_out) begin
        dout_sr <= {dout_sr[6:0], 1'b0};
        serial_data_pin_out <= dout_sr[6];
      end
      if (bit_cnt == ADDR_BITS - 5'h01) begin
        addr_done <= 1'b1;
      end
      if (bit_cnt == FRAME_BITS - 5'h01) begin
        frame_done <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Crossings into the system clock domain
  // ************************************************************
  // Levels only; address and data words are static while a level
  // is high, so they are sampled after it is seen in this domain.
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic addr_seen;
  logic frame_seen;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1 <= '0;
      sync2 <= '0;
      addr_seen <= 1'b0;
      frame_seen <= 1'b0;
    end else begin
      sync1 <= {addr_done, frame_done, signal_present, dll_locked,
                color_detected, overloaded, invert_pin_in};
      sync2 <= sync1;
      addr_seen <= sync2[6];
      frame_seen <= sync2[5];
    end
  end

  wire sig_s = sync2[4];
  wire inv_s = sync2[0];
  wire addr_rise = sync2[6] && !addr_seen;
  wire frame_rise = sync2[5] && !frame_seen;

  // ************************************************************
  // Register file
  // ************************************************************
  logic [7:0] len_reg;
  logic [7:0] gain_reg;
  logic [7:0] ovr_reg;
  logic [7:0] ctrl_reg;
  eqsc_state_t state;

  wire [6:0] reg_sel = addr_sr[6:0];
  wire wr_en = frame_rise && !addr_sr[ADDR_RW_BIT];
  wire wr_ctrl = wr_en && reg_sel == ADDR_EQ_CTRL;
  wire [7:0] status_word = {2'b00, state != EQSC_SEEK, sync2[1],
                            sync2[2], !inv_s, sync2[3], sig_s};

  function automatic logic [7:0] reg_read(input logic [6:0] sel);
    case (sel)
      ADDR_IDENT: reg_read = {DEVICE_CODE, REVISION};
      ADDR_STATUS: reg_read = status_word;
      ADDR_LENGTH: reg_read = len_reg;
      ADDR_GAIN: reg_read = gain_reg;
      ADDR_OVERRIDE: reg_read = ovr_reg;
      ADDR_EQ_CTRL: reg_read = ctrl_reg;
      default: reg_read = 8'h00;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len_reg <= RST_LENGTH;
      gain_reg <= RST_GAIN;
      ovr_reg <= RST_OVERRIDE;
      ctrl_reg <= RST_EQ_CTRL;
      read_word <= 8'h00;
    end else begin
      if (addr_rise) begin
        read_word <= reg_read(reg_sel);
      end
      if (wr_en && reg_sel == ADDR_LENGTH) begin
        len_reg <= data_sr & MASK_LENGTH;
      end
      if (wr_en && reg_sel == ADDR_GAIN) begin
        gain_reg <= data_sr & MASK_LENGTH;
      end
      if (wr_en && reg_sel == ADDR_OVERRIDE) begin
        ovr_reg <= data_sr;
      end
      if (wr_ctrl) begin
        ctrl_reg <= data_sr & MASK_EQ_CTRL;
      end
    end
  end

  // ************************************************************
  // Lock engine
  // ************************************************************
  eqsc_state_t next_state;
  logic [6:0] line_cnt;
  logic [6:0] next_line_cnt;
  logic [LW-1:0] loss_cnt;

  wire eqsc_mode_t mode = eqsc_mode_t'(ctrl_reg[1:0]);
  wire enter_cont = wr_ctrl && data_sr[1:0] == EQSC_CONT
                    && mode != EQSC_CONT;
  wire long_loss = loss_cnt >= LW'(LOSS_CYCLES);
  wire lines_done = line_tick && !eq_step
                    && line_cnt == 7'(LOCK_LINES - 1);

  // Polarity changes feed none of this, so they cannot restart it.
  always_comb begin
    next_state = state;
    next_line_cnt = line_cnt;
    case (state)
      EQSC_SEEK: begin
        if (eq_step) begin
          next_line_cnt = 7'h00;
        end else if (lines_done) begin
          next_state = EQSC_LOCK;
          next_line_cnt = 7'h00;
        end else if (line_tick) begin
          next_line_cnt = line_cnt + 7'h01;
        end
      end
      EQSC_LOCK: begin
        if (mode == EQSC_CONT && eq_step) begin
          next_state = EQSC_SEEK;
        end else if (mode == EQSC_SLOSS && !sig_s) begin
          next_state = EQSC_LOSS;
        end
      end
      EQSC_LOSS: begin
        if (mode != EQSC_SLOSS) begin
          next_state = EQSC_LOCK;
        end else if (sig_s) begin
          next_state = long_loss ? EQSC_SEEK : EQSC_LOCK;
        end
      end
      default: next_state = EQSC_SEEK;
    endcase
    // Leaving a locked mode for 00b arms a fresh acquisition
    if (enter_cont || mode == EQSC_MAN) begin
      next_state = EQSC_SEEK;
      next_line_cnt = 7'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= EQSC_SEEK;
      line_cnt <= 7'h00;
      loss_cnt <= '0;
    end else begin
      state <= next_state;
      line_cnt <= next_line_cnt;
      if (state != EQSC_LOSS) begin
        loss_cnt <= '0;
      end else if (!long_loss) begin
        loss_cnt <= loss_cnt + LW'(1);
      end
    end
  end

  // ************************************************************
  // Equalizer control outputs
  // ************************************************************
  wire coax = ctrl_reg[CTRL_CABLE_BIT];
  wire [5:0] len_code = len_reg[5:0];
  wire [5:0] len_eff = coax && len_code > COAX_MAX_LEN ? COAX_MAX_LEN
                       : len_code;
  wire frozen = next_state != EQSC_SEEK && mode != EQSC_CONT
                && mode != EQSC_MAN;
  wire inv_sel = ovr_reg[OVR_INV_SEL_BIT];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lock_out <= 1'b0;
      eq_freeze <= 1'b0;
      eq_restart <= 1'b0;
      manual_enable <= 1'b0;
      manual_length <= 6'h00;
      cable_coax <= 1'b0;
      manual_gain <= 6'h00;
      auto_pol_en <= 1'b1;
      pol_invert <= 1'b0;
    end else begin
      lock_out <= next_state != EQSC_SEEK;
      eq_freeze <= frozen;
      eq_restart <= next_state == EQSC_SEEK && state != EQSC_SEEK;
      manual_enable <= mode == EQSC_MAN;
      manual_length <= len_eff;
      cable_coax <= coax;
      manual_gain <= gain_reg[5:0];
      auto_pol_en <= mode != EQSC_MAN;
      pol_invert <= inv_sel ? ovr_reg[OVR_INV_VAL_BIT] : inv_s;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_cont_no_freeze: assert property (
    mode == EQSC_CONT |=> !eq_freeze) else $error("freeze in mode 00b");
  a_lrst_holds: assert property (
    state == EQSC_LOCK && mode == EQSC_LRST && !wr_ctrl |=> lock_out)
    else $error("lock dropped in lock until reset");
  a_cont_restart: assert property (
    enter_cont |=> state == EQSC_SEEK ##1 !lock_out)
    else $error("no restart on mode 00b");
  a_short_loss: assert property (
    state == EQSC_LOSS && mode == EQSC_SLOSS && sig_s && !long_loss
    && !wr_ctrl |=> state == EQSC_LOCK) else $error("short loss restarted");
  a_long_loss: assert property (
    state == EQSC_LOSS && mode == EQSC_SLOSS && sig_s && long_loss
    && !wr_ctrl |=> state == EQSC_SEEK) else $error("long loss ignored");
  a_lock_lines: assert property (
    state == EQSC_SEEK && lines_done && mode != EQSC_MAN && !wr_ctrl
    |=> state == EQSC_LOCK && lock_out) else $error("no lock at 100");
  a_man_polarity: assert property (
    mode == EQSC_MAN |=> !auto_pol_en && manual_enable)
    else $error("auto polarity in manual");
  a_coax_clamp: assert property (
    coax |=> manual_length <= COAX_MAX_LEN) else $error("coax clamp");
  a_sloss_freeze: assert property (
    mode == EQSC_SLOSS && next_state == EQSC_LOCK |=> eq_freeze)
    else $error("no freeze on lock");
  a_read_drive: assert property (
    @(posedge serial_clk) disable iff (!serial_enable_pin)
    first_out |=> serial_data_pin_oe) else $error("read not driven");

  c_lock_reached: cover property (state == EQSC_SEEK ##1 state == EQSC_LOCK);
  c_long_loss: cover property (state == EQSC_LOSS ##1 state == EQSC_SEEK);
  c_write_ctrl: cover property (wr_ctrl);
  c_read_frame: cover property (addr_rise && addr_sr[ADDR_RW_BIT]);

endmodule // eqsc_serial_ctrl

//--- tb/eqsc_host.sv
// Host microcontroller model that drives the three-wire serial port
`timescale 1ns/1ps

module eqsc_host #(
  parameter int HALF_NS = 100
) (
  // Serial link
  output logic serial_clk,
  output logic serial_enable_pin,
  output logic host_drive,
  output logic host_oe,
  input wire logic serial_data_line
);
  // ************************************************************
  // Frame engine
  // ************************************************************
  initial begin
    serial_clk = 1'b0;
    serial_enable_pin = 1'b0;
    host_drive = 1'b0;
    host_oe = 1'b0;
  end

  // The clock stands low outside frames; 200 ns period is 5 MHz
  task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata,
                      input int nbits, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {addr, wdata};
    rdata = 8'h00;
    #3.3 serial_enable_pin = 1'b1;
    for (int i = 0; i < nbits; i++) begin
      if (i < 8 || !addr[7]) begin
        host_oe = 1'b1;
        host_drive = frame[15 - i];
      end else if (host_oe) begin
        // A released line shows the inverse of the last bit, not a hold
        host_oe = 1'b0;
        host_drive = ~host_drive;
      end
      #(HALF_NS) serial_clk = 1'b1;
      #(HALF_NS) serial_clk = 1'b0;
      if (i >= 8) rdata[15 - i] = serial_data_line;
    end
    #(HALF_NS) serial_enable_pin = 1'b0;
    host_oe = 1'b0;
    host_drive = ~host_drive;
    #(HALF_NS);
  endtask

endmodule // eqsc_host

//--- tb/eqsc_serial_ctrl_bench.sv
// Self-checking bench for the equalizer serial control block
`timescale 1ns/1ps

module eqsc_serial_ctrl_bench;
  import eqsc_pkg::*;

  // ************************************************************
  // Clock, stimulus and wiring
  // ************************************************************
  localparam int LOSS_N = 50;
  localparam logic [3:0] REV = 4'h2;
  // Arbitrary neutral value
  localparam logic [3:0] CODE = 4'h9;
  logic sys_clk = 1'b0, sys_rst = 1'b1;
  logic present = 1'b0, dll = 1'b0, color = 1'b0, ovl = 1'b0;
  logic inv_pin = 1'b0, line_tick = 1'b0, eq_step = 1'b0;
  logic s_clk, s_en, h_d, h_oe, d_out, d_oe, line;
  logic lock_out, eq_freeze, eq_restart, man_en, coax, auto_pol, pol_inv;
  logic [5:0] man_len, man_gain;
  logic [7:0] regs [6];
  logic [7:0] rdv;
  logic mlock = 1'b0;
  int errors = 0, check_count = 0, restarts = 0, seed = 83977, snap;

  always #5 sys_clk = ~sys_clk;
  assign line = d_oe ? d_out : h_d;
  always @(posedge sys_clk) if (eq_restart === 1'b1) restarts++;

  // Both ends driving the data line at once breaks the read handover
  always @(negedge s_clk) begin
    if (h_oe === 1'b1 && d_oe === 1'b1) begin
      errors++;
      $display("wrong value line drivers expected 1 seen 2");
    end
  end

  eqsc_host i_host (.serial_clk(s_clk), .serial_enable_pin(s_en),
    .host_drive(h_d), .host_oe(h_oe), .serial_data_line(line));

  eqsc_serial_ctrl #(.LOSS_CYCLES(LOSS_N), .REVISION(REV),
    .DEVICE_CODE(CODE)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .serial_clk(s_clk), .serial_enable_pin(s_en),
    .serial_data_pin_in(line), .serial_data_pin_out(d_out),
    .serial_data_pin_oe(d_oe), .signal_present(present),
    .dll_locked(dll), .color_detected(color), .overloaded(ovl),
    .invert_pin_in(inv_pin), .line_tick(line_tick), .eq_step(eq_step),
    .lock_out(lock_out), .eq_freeze(eq_freeze), .eq_restart(eq_restart),
    .manual_enable(man_en), .manual_length(man_len), .cable_coax(coax),
    .manual_gain(man_gain), .auto_pol_en(auto_pol), .pol_invert(pol_inv));

  // ************************************************************
  // Checks and bus tasks
  // ************************************************************
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_out();
    logic [5:0] len;
    len = regs[2][5:0];
    if (regs[5][4] && len > COAX_MAX_LEN) len = COAX_MAX_LEN;
    chk("manual_length", {2'b0, len}, {2'b0, man_len});
    chk("manual_gain", {2'b0, regs[3][5:0]}, {2'b0, man_gain});
    chk("cable_coax", {7'h0, regs[5][4]}, {7'h0, coax});
    chk("manual_en", {7'h0, &regs[5][1:0]}, {7'h0, man_en});
    chk("auto_pol", {7'h0, ~&regs[5][1:0]}, {7'h0, auto_pol});
    chk("pol_invert", {7'h0, regs[4][6] ? regs[4][7] : inv_pin},
        {7'h0, pol_inv});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer({1'b0, a}, d, 16, rdv);
    if (a == 7'h02 || a == 7'h03) regs[a] = d & MASK_LENGTH;
    if (a == 7'h04) regs[4] = d;
    if (a == 7'h05) regs[5] = d & MASK_EQ_CTRL;
    repeat (8) @(posedge sys_clk);
    #1 chk_out();
  endtask

  task automatic rd(input logic [6:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == 7'h00) e = {CODE, REV};
    if (a == 7'h01) e = {2'b0, mlock, ovl, color, ~inv_pin, dll, present};
    if (a >= 7'h02 && a <= 7'h05) e = regs[a];
    i_host.xfer({1'b1, a}, 8'h00, 16, rdv);
    chk("read data", e, rdv);
  endtask

  task automatic lk(input logic l, input logic f);
    chk("lock_out", {7'h0, l}, {7'h0, lock_out});
    chk("eq_freeze", {7'h0, f}, {7'h0, eq_freeze});
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 line_tick = 1'b1;
      @(posedge sys_clk);
      #1 line_tick = 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic loss(input int n);
    @(posedge sys_clk);
    #1 present = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 present = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400_000;
    errors++;
    close_out();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    regs = '{8'h00, 8'h00, RST_LENGTH, RST_GAIN, RST_OVERRIDE, RST_EQ_CTRL};
    repeat (20) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 {dll, color, ovl, inv_pin} = 4'($random(seed));
    present = 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(7'h00);
    rd(7'h01);
    for (int a = 2; a < 6; a++) rd(a[6:0]);
    wr(7'h00, 8'hFF);
    wr(7'h7F, 8'h55);
    rd(7'h00);
    rd(7'h7F);
    repeat (3) begin
      wr(7'h02, 8'($random(seed)));
      rd(7'h02);
    end
    wr(7'h03, 8'($random(seed)));
    wr(7'h04, 8'hC0);
    wr(7'h04, 8'h00);
    // Every mode with both cable types; ends in manual coax
    for (int i = 0; i < 8; i++)
      wr(7'h05, {3'h0, i[2], 2'b00, i[1:0]});
    wr(7'h02, 8'h3F);
    wr(7'h02, 8'h13);
    // Continuous update locks after clean lines and unlocks on a step
    wr(7'h05, 8'h00);
    ticks(99);
    lk(1'b0, 1'b0);
    ticks(1);
    lk(1'b1, 1'b0);
    @(posedge sys_clk);
    #1 eq_step = 1'b1;
    @(posedge sys_clk);
    #1 eq_step = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 lk(1'b0, 1'b0);
    // Lock until reset survives loss and polarity toggles
    wr(7'h05, 8'h02);
    ticks(100);
    lk(1'b1, 1'b1);
    mlock = 1'b1;
    rd(7'h01);
    snap = restarts;
    loss(200);
    lk(1'b1, 1'b1);
    @(posedge sys_clk);
    #1 inv_pin = ~inv_pin;
    wr(7'h04, 8'hC0);
    wr(7'h04, 8'h00);
    lk(1'b1, 1'b1);
    chk("restarts", 8'(snap), 8'(restarts));
    wr(7'h05, 8'h00);
    wr(7'h05, 8'h02);
    mlock = 1'b0;
    lk(1'b0, 1'b0);
    chk("restarted", 8'h01, {7'h0, restarts > snap});
    // Lock until signal loss: short losses keep the frozen setting
    wr(7'h05, 8'h01);
    ticks(100);
    lk(1'b1, 1'b1);
    snap = restarts;
    loss(LOSS_N / 3);
    lk(1'b1, 1'b1);
    chk("restarts", 8'(snap), 8'(restarts));
    loss(LOSS_N * 3);
    lk(1'b0, 1'b0);
    chk("restarted", 8'h01, {7'h0, restarts > snap});
    wr(7'h05, 8'h03);
    lk(1'b0, 1'b0);
    // Aborted frames: the line is released and nothing is written
    i_host.xfer(8'h82, 8'h00, 12, rdv);
    chk("data oe", 8'h00, {7'h0, d_oe});
    i_host.xfer(8'h02, 8'h2A, 10, rdv);
    rd(7'h02);
    // A mid-run reset ends lock until reset and restores the defaults
    wr(7'h05, 8'h02);
    ticks(100);
    lk(1'b1, 1'b1);
    @(posedge sys_clk);
    #1 sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    regs = '{8'h00, 8'h00, RST_LENGTH, RST_GAIN, RST_OVERRIDE, RST_EQ_CTRL};
    lk(1'b0, 1'b0);
    rd(7'h05);
    rd(7'h02);
    rd(7'h03);
    close_out();
  end

endmodule // eqsc_serial_ctrl_bench
